/* File: hdl/ads_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module ads_ctrl #(
  parameter int CNT_W = 9,
  parameter int DATA_W = 10
) (
  input wire logic sys_clk_i,              // 25 MHz system clock
  input wire logic arst_n_i,               // Async reset, active low
  input wire logic [4:0] address_i,        // Avalon byte address
  input wire logic read_i,                 // Avalon read
  input wire logic write_i,                // Avalon write
  input wire logic [31:0] writedata_i,     // Avalon write data
  input wire logic [3:0] byteenable_i,     // Avalon byte enables
  output logic [31:0] readdata_o,          // Avalon read data
  output logic waitrequest_o,              // Avalon wait request
  input wire logic timer_trig_i,           // Timer start pulse
  input wire logic ext_trig_n_i,           // external_trigger_pin
  input wire logic [DATA_W-1:0] adc_data_i,  // Converted value
  output logic analog_power_o,             // Analog supply enable
  output logic sample_o,                   // Sample-and-hold active
  output logic convert_o,                  // Conversion active
  output logic irq_o                       // conv_end_interrupt
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  ads_pkg::ads_state_t state_reg, state_next;
  logic wait_reg, start_reg, cks_reg, pwr_reg, primed_reg, run_hs_reg;
  logic apwr_reg, sample_reg, convert_reg, irq_reg;
  logic [1:0] trg_reg;
  logic [ads_pkg::CNT_FIELD_W-1:0] cnt_field_reg, left_reg;
  logic [ads_pkg::IRQ_W-1:0] stat_reg, ena_reg, stat_next, evt;
  logic [DATA_W-1:0] result_reg;
  logic [31:0] rdata_reg, rd_mux;
  logic wr_acc, rd_take, sw_start, pin_fall, trig_fire, start_go;
  logic tmr_load, tmr_zero, capture, done_evt, busy;
  logic [CNT_W-1:0] tmr_val;
  logic [CNT_W-1:0] samp_cnt_reg;

  // Phase lengths minus one; the select bit sets the basic clock
  function automatic logic [CNT_W-1:0] spl_m1(input logic clock_select_bit);
    spl_m1 = CNT_W'(clock_select_bit ? ads_pkg::SPL1_CYC - 1 : ads_pkg::SPL0_CYC - 1);
  endfunction

  function automatic logic [CNT_W-1:0] tcp_m1(input logic clock_select_bit);
    tcp_m1 = CNT_W'(clock_select_bit ? ads_pkg::TCP1_CYC - 1 : ads_pkg::TCP0_CYC - 1);
  endfunction

  function automatic logic [CNT_W-1:0] nxt_m1(input logic clock_select_bit,
                                              input logic hs);
    int div;
    div = clock_select_bit ? ads_pkg::BASIC_DIV1 : ads_pkg::BASIC_DIV0;
    if (hs) begin
      nxt_m1 = CNT_W'(clock_select_bit ? ads_pkg::NEXT1_CYC - 1
                          : ads_pkg::NEXT0_CYC - 1);
    end else begin
      nxt_m1 = CNT_W'(ads_pkg::LP_NEXT_BASIC * div - 1);
    end
  endfunction

  // ****************************************************************
  // Avalon-MM slave, one wait state on every access
  // ****************************************************************
  assign wr_acc = write_i & ~wait_reg & byteenable_i[0];
  assign rd_take = read_i & wait_reg;

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((read_i | write_i) & wait_reg);
    end
  end

  // Read data is a snapshot taken one cycle before the answer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_i)
      ads_pkg::OFS_CSR: begin
        rd_mux[ads_pkg::CSR_START] = start_reg;
        rd_mux[ads_pkg::CSR_CKS] = cks_reg;
        rd_mux[ads_pkg::CSR_PWR] = pwr_reg;
        rd_mux[ads_pkg::CSR_BUSY] = busy;
        rd_mux[ads_pkg::CSR_APWR] = apwr_reg;
        rd_mux[ads_pkg::CSR_PRIMED] = primed_reg;
      end
      ads_pkg::OFS_CTRL: begin
        rd_mux[ads_pkg::CTRL_TRG_LSB +: 2] = trg_reg;
        rd_mux[ads_pkg::CTRL_CNT_LSB +: ads_pkg::CNT_FIELD_W] =
          cnt_field_reg;
      end
      ads_pkg::OFS_STAT: rd_mux[ads_pkg::IRQ_W-1:0] = stat_reg;
      ads_pkg::OFS_ENA: rd_mux[ads_pkg::IRQ_W-1:0] = ena_reg;
      ads_pkg::OFS_RES: rd_mux[DATA_W-1:0] = result_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_mux;
    end
  end

  // Mode bits; select and count are frozen while a run is active
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cks_reg <= 1'b0;
      pwr_reg <= 1'b0;
      trg_reg <= ads_pkg::TRG_NONE;
      cnt_field_reg <= ads_pkg::CTRL_RST[ads_pkg::CTRL_CNT_LSB +:
                                         ads_pkg::CNT_FIELD_W];
      ena_reg <= ads_pkg::IRQ_RST;
    end else if (wr_acc) begin
      if (address_i == ads_pkg::OFS_CSR) begin
        if (!busy) begin
          cks_reg <= writedata_i[ads_pkg::CSR_CKS];
        end
        pwr_reg <= writedata_i[ads_pkg::CSR_PWR];
      end
      if (address_i == ads_pkg::OFS_CTRL) begin
        trg_reg <= writedata_i[ads_pkg::CTRL_TRG_LSB +: 2];
        if (!busy) begin
          cnt_field_reg <=
            writedata_i[ads_pkg::CTRL_CNT_LSB +: ads_pkg::CNT_FIELD_W];
        end
      end
      if (address_i == ads_pkg::OFS_ENA) begin
        ena_reg <= writedata_i[ads_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Start sources
  // ****************************************************************
  ads_pin_sync u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pin_n_i(ext_trig_n_i),
    .fall_o(pin_fall)
  );

  assign trig_fire = (trg_reg == ads_pkg::TRG_TIMER & timer_trig_i) |
                     (trg_reg == ads_pkg::TRG_PIN & pin_fall);
  assign sw_start = wr_acc & (address_i == ads_pkg::OFS_CSR) &
                    writedata_i[ads_pkg::CSR_START];
  assign start_go = (state_reg == ads_pkg::ST_IDLE) &
                    (sw_start | trig_fire);
  assign busy = (state_reg != ads_pkg::ST_IDLE);

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  ads_phase_timer #(.CNT_W(CNT_W)) u_timer (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .zero_o(tmr_zero)
  );

  assign capture = tmr_zero & (state_reg == ads_pkg::ST_CONV |
                               state_reg == ads_pkg::ST_NEXT);
  assign done_evt = capture & (left_reg == '0);

  // Next state and the length of the phase being entered
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_reg)
      ads_pkg::ST_IDLE: begin
        if (start_go) begin
          state_next = ads_pkg::ST_DELAY;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(ads_pkg::TD_CYC - 1);
          if (!primed_reg) begin
            tmr_val = CNT_W'(ads_pkg::TD_CYC + ads_pkg::WARM_CYC - 1);
          end
        end
      end
      ads_pkg::ST_DELAY: begin
        if (tmr_zero) begin
          state_next = ads_pkg::ST_SAMPLE;
          tmr_load = 1'b1;
          tmr_val = spl_m1(cks_reg);
        end
      end
      ads_pkg::ST_SAMPLE: begin
        if (tmr_zero) begin
          state_next = ads_pkg::ST_CONV;
          tmr_load = 1'b1;
          tmr_val = tcp_m1(cks_reg);
        end
      end
      ads_pkg::ST_CONV, ads_pkg::ST_NEXT: begin
        if (tmr_zero) begin
          if (left_reg == '0) begin
            state_next = ads_pkg::ST_IDLE;
          end else begin
            state_next = ads_pkg::ST_NEXT;
            tmr_load = 1'b1;
            tmr_val = nxt_m1(cks_reg, run_hs_reg);
          end
        end
      end
      default: state_next = ads_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ads_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Run bookkeeping: mode is latched at start, count per capture
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left_reg <= '0;
      run_hs_reg <= 1'b0;
    end else if (start_go) begin
      left_reg <= cnt_field_reg;
      run_hs_reg <= pwr_reg;
    end else if (capture && left_reg != '0) begin
      left_reg <= left_reg - 1'b1;
    end
  end

  // Start bit: set by either source, cleared at end of run
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_reg <= 1'b0;
    end else if (start_go) begin
      start_reg <= 1'b1;
    end else if (done_evt) begin
      start_reg <= 1'b0;
    end
  end

  // Ready state survives only while high-speed power is kept on
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      primed_reg <= 1'b0;
    end else if (!pwr_reg) begin
      primed_reg <= 1'b0;
    end else if (done_evt && run_hs_reg) begin
      primed_reg <= 1'b1;
    end
  end

  // Result capture at the end of each operating phase
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_reg <= '0;
    end else if (capture) begin
      result_reg <= adc_data_i;
    end
  end

  // ****************************************************************
  // Analog side outputs, registered from next state
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      apwr_reg <= 1'b0;
      sample_reg <= 1'b0;
      convert_reg <= 1'b0;
    end else begin
      apwr_reg <= pwr_reg | (state_next != ads_pkg::ST_IDLE);
      sample_reg <= (state_next == ads_pkg::ST_SAMPLE);
      convert_reg <= (state_next == ads_pkg::ST_CONV) |
                     (state_next == ads_pkg::ST_NEXT);
    end
  end

  // ****************************************************************
  // Interrupt status, clear and enable
  // ****************************************************************
  assign evt[ads_pkg::IRQ_END] = done_evt;
  assign evt[ads_pkg::IRQ_OVR] = trig_fire & busy;

  // A new event in the clearing cycle wins over the clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_acc && address_i == ads_pkg::OFS_CLR) begin
      stat_next = stat_reg & ~writedata_i[ads_pkg::IRQ_W-1:0];
    end
    stat_next = stat_next | evt;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_reg <= ads_pkg::IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & ena_reg);
    end
  end

  assign readdata_o = rdata_reg;
  assign waitrequest_o = wait_reg;
  assign analog_power_o = apwr_reg;
  assign sample_o = sample_reg;
  assign convert_o = convert_reg;
  assign irq_o = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Phase cycle counter read only by the checks
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      samp_cnt_reg <= '0;
    end else if (state_next != state_reg || tmr_load) begin
      // A reload restarts the count, so back-to-back later phases work
      samp_cnt_reg <= '0;
    end else begin
      samp_cnt_reg <= samp_cnt_reg + 1'b1;
    end
  end

  a_start_power: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(start_reg) |-> analog_power_o)
    else $error("analog power not on with start");

  a_cold_delay: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(state_reg == ads_pkg::ST_DELAY) && !primed_reg |->
      ##201 state_reg == ads_pkg::ST_DELAY
      ##1 state_reg == ads_pkg::ST_SAMPLE)
    else $error("cold start delay is not 202 cycles");

  a_warm_delay: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(state_reg == ads_pkg::ST_DELAY) && primed_reg |->
      ##1 state_reg == ads_pkg::ST_DELAY
      ##1 state_reg == ads_pkg::ST_SAMPLE)
    else $error("warm start delay is not 2 cycles");

  a_sample_len: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state_reg == ads_pkg::ST_SAMPLE && state_next != state_reg |->
      samp_cnt_reg == (cks_reg ? 9'h027 : 9'h013))
    else $error("sampling length wrong");

  a_conv_len: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state_reg == ads_pkg::ST_CONV && state_next != state_reg |->
      samp_cnt_reg == (cks_reg ? 9'h028 : 9'h014))
    else $error("operating length wrong");

  a_next_len: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    state_reg == ads_pkg::ST_NEXT && tmr_zero |->
      samp_cnt_reg == (cks_reg ? 9'h027 : 9'h013))
    else $error("later conversion length wrong");

  a_end_clear: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    done_evt |=> !start_reg && stat_reg[ads_pkg::IRQ_END])
    else $error("end did not clear start or set flag");

  a_power_off: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !pwr_reg && state_next == ads_pkg::ST_IDLE |=> !analog_power_o)
    else $error("analog power left on");

  a_power_hold: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    pwr_reg |=> analog_power_o)
    else $error("analog power dropped in high-speed mode");

  a_trig_start: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    trig_fire && !busy |=> start_reg &&
      state_reg == ads_pkg::ST_DELAY)
    else $error("trigger did not start conversion");

  a_irq_level: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    ##1 irq_o == |($past(stat_next) & $past(ena_reg)))
    else $error("interrupt does not follow status and enable");
endmodule // ads_ctrl
`default_nettype wire

/* File: hdl/ads_phase_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Down counter timing one sequencer phase
// ****************************************************************
module ads_phase_timer #(
  parameter int CNT_W = 9
) (
  input wire logic sys_clk_i,              // System clock
  input wire logic arst_n_i,               // Async reset, active low
  input wire logic load_i,                 // Load phase length
  input wire logic [CNT_W-1:0] value_i,    // Length minus one
  output logic zero_o                      // Last cycle of phase
);
  logic [CNT_W-1:0] cnt_reg;

  // Saturates at zero so an idle timer stays quiet
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= value_i;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign zero_o = (cnt_reg == '0);
endmodule // ads_phase_timer
`default_nettype wire

/* File: hdl/ads_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Pin synchroniser with falling-edge detect
// ****************************************************************
module ads_pin_sync (
  input wire logic sys_clk_i,   // System clock
  input wire logic arst_n_i,    // Async reset, active low
  input wire logic pin_n_i,     // Asynchronous active-low pin
  output logic fall_o           // One-cycle pulse on assertion
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Three flops; only the last two feed the edge detector
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_n_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Falling edge means the pin was asserted
  assign fall_o = prev_reg & ~sync_reg;
endmodule // ads_pin_sync
`default_nettype wire

/* File: hdl/ads_pkg.sv */
// ****************************************************************
// Shared constants of the converter start and power controller
// ****************************************************************
package ads_pkg;

  // ****************************************************************
  // Register map, byte offsets on the bus
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CSR = 5'h00;   // conv_control_status_reg
  localparam logic [4:0] OFS_CTRL = 5'h04;  // conv_control_reg
  localparam logic [4:0] OFS_STAT = 5'h08;  // Sticky event status
  localparam logic [4:0] OFS_CLR = 5'h0C;   // Write-one-to-clear
  localparam logic [4:0] OFS_ENA = 5'h10;   // Event enables
  localparam logic [4:0] OFS_RES = 5'h14;   // result_reg_a

  // Field positions
  localparam int CSR_START = 0;   // conv_start_bit
  localparam int CSR_CKS = 1;     // clock_select_bit
  localparam int CSR_PWR = 2;     // power_mode_bit
  localparam int CSR_BUSY = 3;
  localparam int CSR_APWR = 4;
  localparam int CSR_PRIMED = 5;
  localparam int CTRL_TRG_LSB = 0;  // trigger_select_lo, _hi above
  localparam int CTRL_CNT_LSB = 4;  // Extra consecutive conversions
  localparam int CNT_FIELD_W = 4;
  localparam int IRQ_END = 0;       // conv_end_flag
  localparam int IRQ_OVR = 1;       // Trigger while busy
  localparam int IRQ_W = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Trigger select codes
  localparam logic [1:0] TRG_NONE = 2'h0;
  localparam logic [1:0] TRG_TIMER = 2'h1;
  localparam logic [1:0] TRG_PIN = 2'h2;

  // ****************************************************************
  // Timing, in states; one state is one sys_clk period (40 ns)
  // ****************************************************************
  localparam int CLK_PER_STATE = 1;
  localparam int TD_X10 = 15;          // Start delay, tenths of a state
  localparam int TCONV0_X10 = 425;     // Whole conversion, select 0
  localparam int TCONV1_X10 = 825;     // Whole conversion, select 1
  localparam int TSPL0 = 20;           // Sampling, select 0
  localparam int TSPL1 = 40;           // Sampling, select 1
  localparam int WARM_STATES = 200;    // Analog warm-up
  localparam int NEXT0 = 20;           // Later operating time, select 0
  localparam int NEXT1 = 40;           // Later operating time, select 1
  localparam int BASIC_DIV0 = 2;       // States per basic clock, sel 0
  localparam int BASIC_DIV1 = 4;       // States per basic clock, sel 1
  localparam int LP_NEXT_BASIC = 10;   // Later conversion, basic clocks

  // Derived cycle counts; a least time rounds up
  localparam int TD_CYC = (TD_X10 * CLK_PER_STATE + 9) / 10;
  localparam int WARM_CYC = WARM_STATES * CLK_PER_STATE;
  localparam int SPL0_CYC = TSPL0 * CLK_PER_STATE;
  localparam int SPL1_CYC = TSPL1 * CLK_PER_STATE;
  localparam int TCP0_CYC =
    ((TCONV0_X10 - TD_X10 - 10 * TSPL0) * CLK_PER_STATE + 9) / 10;
  localparam int TCP1_CYC =
    ((TCONV1_X10 - TD_X10 - 10 * TSPL1) * CLK_PER_STATE + 9) / 10;
  localparam int NEXT0_CYC = NEXT0 * CLK_PER_STATE;
  localparam int NEXT1_CYC = NEXT1 * CLK_PER_STATE;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_SAMPLE = 5'h04,
    ST_CONV = 5'h08,
    ST_NEXT = 5'h10
  } ads_state_t;

endpackage

/* File: verif/adc_start_power_timing_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_start_power_timing_ctrl_tb_top;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, tmr = 0, pin_n = 1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic wreq, apwr, spl, cnv, irq;
  logic [9:0] adc;
  int mismatches = 0, n_checks = 0, spl_n = 0, cnv_n = 0;

  // ****************************************************************
  // Design and analog model
  // ****************************************************************
  ads_ctrl dut (.sys_clk_i(clk), .arst_n_i(rst_n), .address_i(addr),
    .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq),
    .timer_trig_i(tmr), .ext_trig_n_i(pin_n), .adc_data_i(adc),
    .analog_power_o(apwr), .sample_o(spl), .convert_o(cnv),
    .irq_o(irq));
  ads_analog_model model (.analog_power_i(apwr), .convert_i(cnv),
    .adc_data_o(adc));

  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  // Phase length counters
  always @(posedge clk) begin
    if (spl === 1'b1) spl_n++;
    if (cnv === 1'b1) cnv_n++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Delay to sampling, then sample and convert lengths of one run
  task automatic conv(input int n, input int s, input int c);
    int k;
    k = 0;
    spl_n = 0;
    cnv_n = 0;
    do begin
      @(posedge clk);
      k++;
      #1;
    end while (spl !== 1'b1 && k < 400);
    if (n >= 0) chk(k, n);
    while (spl !== 1'b0 || cnv !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    chk(spl_n, s);
    chk(cnv_n, c);
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, about ten times the under two thousand cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, ads_pkg::OFS_CSR, 0);
    chk(v, 0);
    chk(apwr, 0);
    acc(0, 5'h18, 0);
    chk(v, 0);
    acc(1, ads_pkg::OFS_ENA, 1);
    acc(1, ads_pkg::OFS_CSR, 1);
    conv(202, 20, 21);
    tick();
    chk(irq, 1);
    chk(apwr, 0);
    acc(0, ads_pkg::OFS_CSR, 0);
    chk(v, 0);
    acc(0, ads_pkg::OFS_RES, 0);
    chk(v, 32'h2A5);
    acc(1, ads_pkg::OFS_CLR, 1);
    tick();
    chk(irq, 0);
    acc(1, ads_pkg::OFS_CTRL, 32'h10);
    acc(1, ads_pkg::OFS_CSR, 4);
    tick();
    chk(apwr, 1);
    acc(1, ads_pkg::OFS_CSR, 5);
    conv(202, 20, 41);
    acc(1, ads_pkg::OFS_CSR, 5);
    conv(2, 20, 41);
    acc(0, ads_pkg::OFS_CSR, 0);
    chk(v, 32'h34);
    acc(1, ads_pkg::OFS_CSR, 0);
    tick();
    chk(apwr, 0);
    acc(1, ads_pkg::OFS_CSR, 3);
    conv(202, 40, 81);
    acc(1, ads_pkg::OFS_CTRL, 1);
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    conv(202, 40, 41);
    acc(1, ads_pkg::OFS_CTRL, 2);
    @(posedge clk);
    pin_n <= 1'b0;
    conv(-1, 40, 41);
    pin_n <= 1'b1;
    acc(0, ads_pkg::OFS_CSR, 0);
    chk(v, 32'h2);
    // Trigger while a run is active is refused and flagged
    acc(1, ads_pkg::OFS_CTRL, 1);
    acc(1, ads_pkg::OFS_CSR, 3);
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    acc(0, ads_pkg::OFS_STAT, 0);
    chk(v, 32'h3);
    conv(-1, 40, 41);
    end_sim;
  end
endmodule // adc_start_power_timing_ctrl_tb_top
`default_nettype wire

/* File: verif/ads_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Analog converter model, driven by power and convert only
// ****************************************************************
module ads_analog_model #(
  parameter logic [9:0] CODE = 10'h2A5  // Arbitrary test code
) (
  input wire logic analog_power_i,  // Supply enable
  input wire logic convert_i,       // Conversion active
  output logic [9:0] adc_data_o     // Converted value
);
  // valid only powered
  // Idle or unpowered shows the inverse so a stale capture is caught
  assign adc_data_o = (analog_power_i && convert_i) ? CODE : ~CODE;
endmodule // ads_analog_model
`default_nettype wire
